// File: hw/cal_regs_map.vh
/*
 * offsets, field positions, reset values and codes for the channel 1
 * calibration words and the channel 2 configuration word.
 * assumes: included by bare name from design files under hw/.
 */
`ifndef CAL_REGS_MAP_VH
`define CAL_REGS_MAP_VH

// register offsets on the host register port
`define OFS_CH1_OFFSET_HIGH 8'h0F
`define OFS_CH1_OFFSET_LOW  8'h10
`define OFS_CH1_GAIN_HIGH   8'h11
`define OFS_CH1_GAIN_LOW    8'h12
`define OFS_CH2_CONFIG      8'h13

// reset values
`define RST_CH1_OFFSET_HIGH 16'h0000
`define RST_CH1_OFFSET_LOW  16'h0000
`define RST_CH1_GAIN_HIGH   16'h8000
`define RST_CH1_GAIN_LOW    16'h0000
`define RST_CH2_CONFIG      16'h0000

// field positions
`define LOW_FIELD_MSB       15
`define LOW_FIELD_LSB       8
`define PHASE_MSB           15
`define PHASE_LSB           6
`define DC_OFF_BIT          2
`define INSEL_MSB           1
`define INSEL_LSB           0

// writable bit masks; zeros are reserved bits
`define MASK_FULL           16'hFFFF
`define MASK_LOW_REG        16'hFF00
`define MASK_CONFIG         16'hFFC7

// input selection codes
`define INSEL_EXTERNAL      2'h0
`define INSEL_SHORTED       2'h1
`define INSEL_TEST_POS      2'h2
`define INSEL_TEST_NEG      2'h3

`endif

// File: hw/masked_reg.v
/*
 * one 16-bit register with a write mask; masked bits hold zero.
 * assumes: single clock, asynchronous active-low reset, write strobe
 * already qualified by address decode.
 */
`timescale 1ns/100ps

module masked_reg #(
    parameter [15:0] RESET_VALUE = 16'h0000,
    parameter [15:0] WRITE_MASK  = 16'hFFFF
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        write_en,
    input  wire [15:0] write_data,
    output wire [15:0] value
);

    reg [15:0] value_q;

    // reserved bits never take written data, so they stay zero
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= RESET_VALUE & WRITE_MASK;
        end else if (write_en) begin
            value_q <= write_data & WRITE_MASK;
        end
    end

    assign value = value_q;

endmodule // masked_reg

// File: hw/adc_channel_calibration_regs.v
/*
 * channel 1 offset/gain calibration and channel 2 configuration
 * registers, with decoded fields handed to the channel datapath.
 * the joined 24-bit offset and gain reach the datapath only once both
 * halves of a pair have been written; a lone half raises a pending flag.
 * channel 2 fields leave the block decoded and registered.
 * assumes: plain register port on the device clock; reads answer in
 * the next cycle; unmapped reads return zero, unmapped writes ignored.
 * assumes: write and read strobes are one cycle long and never overlap.
 * assumes: the global dc filter level comes from another domain and is
 * synchronised here; the correction arithmetic lives in the datapath.
 */
`timescale 1ns/100ps
`include "cal_regs_map.vh"

module adc_channel_calibration_regs #(
    parameter ADDR_WIDTH = 8
) (
    input  wire                  clock,
    input  wire                  rst_n,
    input  wire [ADDR_WIDTH-1:0] reg_addr,
    input  wire [15:0]           reg_wdata,
    input  wire                  reg_write,
    input  wire                  reg_read,
    output reg  [15:0]           reg_rdata,
    input  wire                  global_dc_filter_setting,
    output reg  signed [23:0]    ch1_offset_value,
    output reg  [23:0]           ch1_gain_value,
    output reg                   ch1_pair_pending,
    output reg  signed [9:0]     ch2_phase_delay,
    output reg                   ch2_dc_filter_active,
    output reg  [1:0]            ch2_input_select,
    output reg                   ch2_inputs_shorted,
    output reg                   ch2_test_signal_on,
    output reg                   ch2_test_signal_negative
);

    ////////////////////////////////////////////////////////////////////////
    // address decode and register storage

    localparam NUM_REGS = 5;

    wire [NUM_REGS-1:0]    hit;
    wire [16*NUM_REGS-1:0] reg_values;
    wire [ADDR_WIDTH-1:0]  offsets [0:NUM_REGS-1];

    // table of offsets per register; reset values and masks are chosen in the loop below
    assign offsets[0] = `OFS_CH1_OFFSET_HIGH;
    assign offsets[1] = `OFS_CH1_OFFSET_LOW;
    assign offsets[2] = `OFS_CH1_GAIN_HIGH;
    assign offsets[3] = `OFS_CH1_GAIN_LOW;
    assign offsets[4] = `OFS_CH2_CONFIG;

    // one masked register per entry; the mask blocks writes to reserved
    // bits and zeroes them at reset, so reads need no extra gating
    genvar i;
    generate
        for (i = 0; i < NUM_REGS; i = i + 1) begin : g_reg
            localparam [15:0] RV = (i == 2) ? `RST_CH1_GAIN_HIGH :
                                   (i == 0) ? `RST_CH1_OFFSET_HIGH :
                                   (i == 4) ? `RST_CH2_CONFIG :
                                   `RST_CH1_OFFSET_LOW;
            localparam [15:0] WM = (i == 1 || i == 3) ? `MASK_LOW_REG :
                                   (i == 4) ? `MASK_CONFIG :
                                   `MASK_FULL;
            assign hit[i] = (reg_addr == offsets[i]);
            masked_reg #(
                .RESET_VALUE (RV),
                .WRITE_MASK  (WM)
            ) u_reg (
                .clock      (clock),
                .rst_n      (rst_n),
                .write_en   (reg_write & hit[i]),
                .write_data (reg_wdata),
                .value      (reg_values[16*i +: 16])
            );
        end
    endgenerate

    wire [15:0] offset_high = reg_values[15:0];
    wire [15:0] offset_low  = reg_values[31:16];
    wire [15:0] gain_high   = reg_values[47:32];
    wire [15:0] gain_low    = reg_values[63:48];
    wire [15:0] config_word = reg_values[79:64];

    ////////////////////////////////////////////////////////////////////////
    // read port: data stands only in the cycle after the strobe

    reg [15:0] read_mux;
    integer    k;

    // reserved bits come back zero from the masked storage
    always @* begin
        read_mux = 16'h0000;
        for (k = 0; k < NUM_REGS; k = k + 1) begin
            if (hit[k]) begin
                read_mux = reg_values[16*k +: 16];
            end
        end
    end

    // zero outside the answer cycle, so a stale word never looks fresh
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            reg_rdata <= read_mux;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pair tracking: a half written alone is held back from the datapath

    reg  off_hi_seen_q;
    reg  off_lo_seen_q;
    reg  gain_hi_seen_q;
    reg  gain_lo_seen_q;
    wire wr_off_hi  = reg_write & hit[0];
    wire wr_off_lo  = reg_write & hit[1];
    wire wr_gain_hi = reg_write & hit[2];
    wire wr_gain_lo = reg_write & hit[3];
    wire off_done   = (off_hi_seen_q | wr_off_hi) & (off_lo_seen_q | wr_off_lo);
    wire gain_done  = (gain_hi_seen_q | wr_gain_hi) & (gain_lo_seen_q | wr_gain_lo);

    // timing, counted from the edge that samples the completing write:
    //   edge 0: the half lands in its register, seen flags clear
    //   edge 0: commit flag set from the same completing write
    //   edge 1: joined value copied, visible from here on
    // a lone half sets its seen flag at edge 0 and pending at edge 1
    // either order works; both halves in any sequence commit the pair
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            off_hi_seen_q  <= 1'b0;
            off_lo_seen_q  <= 1'b0;
            gain_hi_seen_q <= 1'b0;
            gain_lo_seen_q <= 1'b0;
        end else begin
            off_hi_seen_q  <= off_done ? 1'b0 : (off_hi_seen_q | wr_off_hi);
            off_lo_seen_q  <= off_done ? 1'b0 : (off_lo_seen_q | wr_off_lo);
            gain_hi_seen_q <= gain_done ? 1'b0 : (gain_hi_seen_q | wr_gain_hi);
            gain_lo_seen_q <= gain_done ? 1'b0 : (gain_lo_seen_q | wr_gain_lo);
        end
    end

    // commit flag: registers update this cycle, so copy one cycle later
    reg off_commit_q;
    reg gain_commit_q;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            off_commit_q  <= 1'b0;
            gain_commit_q <= 1'b0;
        end else begin
            off_commit_q  <= off_done & (wr_off_hi | wr_off_lo);
            gain_commit_q <= gain_done & (wr_gain_hi | wr_gain_lo);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calibration values seen by the datapath

    // reset images of the joined values; a literal cannot be part-selected,
    // so the low halves pass through named constants first
    localparam [15:0] OFF_LOW_RST   = `RST_CH1_OFFSET_LOW;
    localparam [15:0] GAIN_LOW_RST  = `RST_CH1_GAIN_LOW;
    localparam [23:0] OFF_JOIN_RST  = {`RST_CH1_OFFSET_HIGH,
                                       OFF_LOW_RST[`LOW_FIELD_MSB:`LOW_FIELD_LSB]};
    localparam [23:0] GAIN_JOIN_RST = {`RST_CH1_GAIN_HIGH,
                                       GAIN_LOW_RST[`LOW_FIELD_MSB:`LOW_FIELD_LSB]};

    // a pair is copied only on its commit flag
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch1_offset_value <= OFF_JOIN_RST;
            ch1_gain_value   <= GAIN_JOIN_RST;
            ch1_pair_pending <= 1'b0;
        end else begin
            if (off_commit_q) begin
                // signed two's complement, high word on top
                ch1_offset_value <= $signed({offset_high,
                                    offset_low[`LOW_FIELD_MSB:`LOW_FIELD_LSB]});
            end
            if (gain_commit_q) begin
                // unsigned, 8000_00h is unity, lsb = 2/2^24
                ch1_gain_value <= {gain_high,
                                   gain_low[`LOW_FIELD_MSB:`LOW_FIELD_LSB]};
            end
            ch1_pair_pending <= off_hi_seen_q | off_lo_seen_q |
                                gain_hi_seen_q | gain_lo_seen_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel 2 configuration fields

    // global_dc_filter_setting: high means the global filter is on; it
    // comes from another domain, so two flops guard against metastability
    // and the channel output follows a change three edges later
    reg global_dc_meta_q;
    reg global_dc_sync_q;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            global_dc_meta_q <= 1'b0;
            global_dc_sync_q <= 1'b0;
        end else begin
            global_dc_meta_q <= global_dc_filter_setting;
            global_dc_sync_q <= global_dc_meta_q;
        end
    end

    wire [1:0] insel = config_word[`INSEL_MSB:`INSEL_LSB];
    reg        shorted_d;
    reg        test_on_d;
    reg        test_neg_d;

    // input selection decode; the default arm keeps the external pair
    always @* begin
        shorted_d  = 1'b0;
        test_on_d  = 1'b0;
        test_neg_d = 1'b0;
        case (insel)
            `INSEL_EXTERNAL: begin
                shorted_d = 1'b0;
            end
            `INSEL_SHORTED: begin
                shorted_d = 1'b1;
            end
            `INSEL_TEST_POS: begin
                test_on_d = 1'b1;
            end
            `INSEL_TEST_NEG: begin
                test_on_d  = 1'b1;
                test_neg_d = 1'b1;
            end
            default: begin
                shorted_d = 1'b0;
            end
        endcase
    end

    // decoded fields registered so every output leaves a flip-flop
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch2_phase_delay          <= 10'sh000;
            ch2_dc_filter_active     <= 1'b0;
            ch2_input_select         <= `INSEL_EXTERNAL;
            ch2_inputs_shorted       <= 1'b0;
            ch2_test_signal_on       <= 1'b0;
            ch2_test_signal_negative <= 1'b0;
        end else begin
            ch2_phase_delay <= $signed(config_word[`PHASE_MSB:`PHASE_LSB]);
            ch2_dc_filter_active <= global_dc_sync_q &
                                    ~config_word[`DC_OFF_BIT];
            ch2_input_select <= insel;
            ch2_inputs_shorted       <= shorted_d;
            ch2_test_signal_on       <= test_on_d;
            ch2_test_signal_negative <= test_neg_d;
        end
    end

endmodule // adc_channel_calibration_regs

// File: testbench/adc_channel_calibration_regs_chk.sv
/*
 * concurrent checks for the calibration and channel 2 config registers.
 * assumes: bound into the top module, single clock, async active-low reset.
 */
`timescale 1ns/100ps

module cal_regs_chk #(
    parameter ADDR_WIDTH = 8
) (
    input wire                  clock,
    input wire                  rst_n,
    input wire [ADDR_WIDTH-1:0] reg_addr,
    input wire [15:0]           reg_wdata,
    input wire                  reg_write,
    input wire                  reg_read,
    input wire [15:0]           reg_rdata,
    input wire signed [23:0]    ch1_offset_value,
    input wire [23:0]           ch1_gain_value,
    input wire                  ch1_pair_pending,
    input wire signed [9:0]     ch2_phase_delay,
    input wire                  ch2_dc_filter_active,
    input wire [1:0]            ch2_input_select,
    input wire                  ch2_inputs_shorted,
    input wire                  ch2_test_signal_on,
    input wire                  ch2_test_signal_negative
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    // write cycles to each register, the steps of a pair commit
    sequence cfg_wr;     reg_write && reg_addr == 8'h13; endsequence
    sequence gain_hi_wr; reg_write && reg_addr == 8'h11; endsequence
    sequence gain_lo_wr; reg_write && reg_addr == 8'h12; endsequence
    sequence off_hi_wr;  reg_write && reg_addr == 8'h0F; endsequence
    sequence off_lo_wr;  reg_write && reg_addr == 8'h10; endsequence
    ////////////////////////////////////////////////////////////////////////////
    reset_vals_a: assert property (!$past(rst_n) |->
        ch1_gain_value == 24'h80_0000 && ch1_offset_value == 24'h00_0000)
        else $error("calibration outputs wrong after reset");
    low_resv_a: assert property (reg_read && (reg_addr == 8'h10 || reg_addr == 8'h12)
        |=> reg_rdata[7:0] == 8'h00) else $error("reserved low byte not zero");
    cfg_resv_a: assert property (reg_read && reg_addr == 8'h13
        |=> reg_rdata[5:3] == 3'b000) else $error("reserved config bits not zero");
    phase_field_a: assert property (cfg_wr |-> ##2
        ch2_phase_delay == $past(reg_wdata[15:6], 2)) else $error("phase delay field wrong");
    dc_off_a: assert property (cfg_wr ##0 reg_wdata[2] |-> ##2 !ch2_dc_filter_active)
        else $error("dc filter still active");
    input_sel_a: assert property (cfg_wr |-> ##2
        ch2_input_select == $past(reg_wdata[1:0], 2)) else $error("input select wrong");
    test_sig_a: assert property (ch2_test_signal_on == ch2_input_select[1]
        && ch2_inputs_shorted == (ch2_input_select == 2'b01)
        && ch2_test_signal_negative == (ch2_input_select == 2'b11))
        else $error("input select decode wrong");
    // a lone low half leaves the joined value alone and raises pending
    half_hold_a: assert property (!(reg_write && reg_addr == 8'h0F) ##1
        (!ch1_pair_pending && !(reg_write && reg_addr == 8'h0F)) ##1 off_lo_wr |=>
        $stable(ch1_offset_value) ##1 ($stable(ch1_offset_value) && ch1_pair_pending))
        else $error("offset changed on a half write");
    gain_pair_a: assert property (gain_hi_wr ##0 !ch1_pair_pending ##1 gain_lo_wr
        |-> ##2 ch1_gain_value == {$past(reg_wdata, 3), $past(reg_wdata[15:8], 2)})
        else $error("gain commit wrong");
    off_pair_a: assert property (off_lo_wr ##0 !ch1_pair_pending ##3 off_hi_wr
        |-> ##2 ch1_offset_value == {$past(reg_wdata, 2), $past(reg_wdata[15:8], 5)})
        else $error("offset commit wrong");
endmodule // cal_regs_chk

bind adc_channel_calibration_regs cal_regs_chk #(.ADDR_WIDTH(ADDR_WIDTH)) i_chk (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .ch1_offset_value(ch1_offset_value), .ch1_gain_value(ch1_gain_value),
    .ch1_pair_pending(ch1_pair_pending), .ch2_phase_delay(ch2_phase_delay),
    .ch2_dc_filter_active(ch2_dc_filter_active), .ch2_input_select(ch2_input_select),
    .ch2_inputs_shorted(ch2_inputs_shorted), .ch2_test_signal_on(ch2_test_signal_on),
    .ch2_test_signal_negative(ch2_test_signal_negative));

// File: testbench/adc_channel_calibration_regs_tb_top.sv
/*
 * self-checking bench for the calibration and channel 2 config registers.
 * assumes: register port answers reads in the next cycle, 100 MHz clock.
 */
`timescale 1ns/100ps

module adc_channel_calibration_regs_tb_top;
    logic               clock, rst_n, reg_write, reg_read, global_dc_filter_setting;
    logic        [7:0]  reg_addr;
    logic        [15:0] reg_wdata, reg_rdata;
    logic signed [23:0] ch1_offset_value;
    logic        [23:0] ch1_gain_value;
    logic signed [9:0]  ch2_phase_delay;
    logic        [1:0]  ch2_input_select;
    logic               ch1_pair_pending, ch2_dc_filter_active, ch2_inputs_shorted;
    logic               ch2_test_signal_on, ch2_test_signal_negative;
    int                 n_errors, n_tests;

    adc_channel_calibration_regs i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .global_dc_filter_setting(global_dc_filter_setting),
        .ch1_offset_value(ch1_offset_value), .ch1_gain_value(ch1_gain_value),
        .ch1_pair_pending(ch1_pair_pending), .ch2_phase_delay(ch2_phase_delay),
        .ch2_dc_filter_active(ch2_dc_filter_active), .ch2_input_select(ch2_input_select),
        .ch2_inputs_shorted(ch2_inputs_shorted), .ch2_test_signal_on(ch2_test_signal_on),
        .ch2_test_signal_negative(ch2_test_signal_negative));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // strobes are never lowered here, so writes can follow with no gap
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask
    task automatic idle(input int n);
        @(posedge clock);
        reg_write <= 1'b0;
        repeat (n) @(posedge clock);
        #1;
    endtask
    // read data only stands in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read  <= 1'b1;
        reg_addr  <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(8'h0F, 16'h0000);
        rd_chk(8'h11, 16'h8000);
        rd_chk(8'h13, 16'h0000);
        check("gain", ch1_gain_value, 24'h80_0000);
        check("offset", ch1_offset_value, 24'h00_0000);
        $display("t_reset done");
    endtask
    // all ones everywhere, unmapped neighbours too; reserved bits must stay zero
    task automatic t_regs();
        logic [7:0] a;
        for (a = 8'h0E; a <= 8'h14; a++) wr(a, 16'hFFFF);
        idle(3);
        rd_chk(8'h0F, 16'hFFFF);
        rd_chk(8'h10, 16'hFF00);
        rd_chk(8'h11, 16'hFFFF);
        rd_chk(8'h12, 16'hFF00);
        rd_chk(8'h14, 16'h0000);
        check("offset", ch1_offset_value, 24'hFF_FFFF);
        check("gain", ch1_gain_value, 24'hFF_FFFF);
        $display("t_regs done");
    endtask
    task automatic t_pair();
        wr(8'h10, 16'h3400);
        idle(1);
        check("pending", ch1_pair_pending, 24'h00_0001);
        check("offset", ch1_offset_value, 24'hFF_FFFF);
        wr(8'h0F, 16'h8012);
        idle(2);
        check("offset", ch1_offset_value, 24'h80_1234);
        check("negative", ch1_offset_value < 0, 24'h00_0001);
        wr(8'h11, 16'h4000);
        wr(8'h12, 16'hAB00);
        idle(2);
        check("gain", ch1_gain_value, 24'h40_00AB);
        check("pending", ch1_pair_pending, 24'h00_0000);
        $display("t_pair done");
    endtask
    // every input selection with and without the per-channel filter override
    task automatic t_cfg();
        logic [3:0]  i;
        logic [15:0] w;
        for (i = 4'h0; i < 4'h8; i++) begin
            w = {10'h200, 3'b111, i[2:0]};
            wr(8'h13, w);
            idle(3);
            check("phase", {14'h0000, ch2_phase_delay}, 24'h00_0200);
            check("select", ch2_input_select, i[1:0]);
            check("shorted", ch2_inputs_shorted, i[1:0] == 2'b01);
            check("test_on", ch2_test_signal_on, i[1]);
            check("test_neg", ch2_test_signal_negative, i[1:0] == 2'b11);
            check("dc_active", ch2_dc_filter_active, !i[2]);
            rd_chk(8'h13, w & 16'hFFC7);
        end
        // clear the override first so only the global level decides
        wr(8'h13, 16'h0000);
        idle(3);
        check("dc_active", ch2_dc_filter_active, 24'h00_0001);
        @(posedge clock);
        global_dc_filter_setting <= 1'b0;
        idle(4);
        check("dc_active", ch2_dc_filter_active, 24'h00_0000);
        $display("t_cfg done");
    endtask
    // reset in mid-run with written pairs and a lone half outstanding
    task automatic t_rerst();
        wr(8'h10, 16'h5500);
        idle(2);
        check("pending", ch1_pair_pending, 24'h00_0001);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(8'h11, 16'h8000);
        rd_chk(8'h0F, 16'h0000);
        rd_chk(8'h13, 16'h0000);
        check("gain", ch1_gain_value, 24'h80_0000);
        check("offset", ch1_offset_value, 24'h00_0000);
        check("pending", ch1_pair_pending, 24'h00_0000);
        $display("t_rerst done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
        global_dc_filter_setting = 1'b1;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_pair();
        t_cfg();
        t_rerst();
        conclude();
    end
    // hang guard
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule // adc_channel_calibration_regs_tb_top
